// ===== dv/tef_far_model.sv
`default_nettype none
module tef_far_model
  import tef_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Activation and per-transfer settings
  input  wire logic [NUM_EV-1:0] transfer_activate,
  input  wire logic              sel,
  input  wire logic [CNT_W-1:0]  rem,
  input  wire logic [3:0]        lag,
  // Transfer reports
  output tef_xfer_s              xfer,
  output logic      [VEC_W-1:0]  active_vector_number
);
  logic             busy;
  logic [4:0]       cnt;
  logic [VEC_W-1:0] src;
  always_comb begin
    src = '0;
    for (int i = 0; i < NUM_EV; i++)
      if (transfer_activate[i]) src = VEC_W'(i);
  end
  // Requests arriving while busy are dropped, as a single-channel controller would.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 5'h0;
      xfer <= '0;
      active_vector_number <= 8'hFF;
    end else begin
      xfer.start <= busy && cnt == {1'b0, lag};
      xfer.done <= busy && cnt == {lag, 1'b0};
      cnt <= cnt + 5'h1;
      if (busy && cnt == {1'b0, lag})
        active_vector_number <= xfer.vector;
      if (busy && cnt == {lag, 1'b0}) begin
        busy <= 1'b0;
        active_vector_number <= 8'hFF;
      end
      if (!busy && |transfer_activate) begin
        busy <= 1'b1;
        cnt <= 5'h0;
        xfer.vector <= src;
        xfer.irq_select <= sel;
        xfer.remaining <= rem;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tef_props.sv
`default_nettype none
module tef_props
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // Design ports
  input wire tef_axil_req_s     axil_req,
  input wire tef_axil_rsp_s     axil_rsp,
  input wire logic [NUM_EV-1:0] event_request,
  input wire logic [NUM_EV-1:0] irq_forward,
  input wire tef_xfer_s         xfer,
  input wire logic [VEC_W-1:0]  active_vector_number,
  input wire logic [NUM_EV-1:0] transfer_activate,
  input wire logic [NUM_EV-1:0] transfer_enable,
  input wire logic [NUM_EV-1:0] request_pending_flag,
  input wire logic [NUM_EV-1:0] transfer_pending
);
  localparam logic [NUM_EV-1:0] FM = {FLG_MASK_HI[9:0], FLG_MASK_LO};
  localparam logic [NUM_EV-1:0] EM = {EN_MASK_HI[9:0], EN_MASK_LO};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_flag_set:
    assert property (1 |=> &(request_pending_flag | ~$past(event_request & FM)))
      else $error("flag not set");
  a_fwd_clear:
    assert property (1 |=> ~|(request_pending_flag & $past(irq_forward & ~event_request)))
      else $error("flag kept after forward");
  a_start_clear:
    assert property (xfer.start && !xfer.irq_select && xfer.remaining != 0
      && !event_request[xfer.vector] |=> !request_pending_flag[$past(xfer.vector)])
      else $error("flag kept after start");
  a_done_clear:
    assert property (xfer.done && (xfer.irq_select || xfer.remaining == 0)
      && !event_request[xfer.vector] |=> !request_pending_flag[$past(xfer.vector)])
      else $error("flag kept after done");
  a_act_cause:
    assert property (1 |=> ~|(transfer_activate & ~$past(event_request & transfer_enable)))
      else $error("activation without enable");
  a_no_phantom:
    assert property (~|(request_pending_flag & ~FM) && ~|(transfer_enable & ~EM))
      else $error("unimplemented bit set");
  a_bresp_hold:
    assert property (axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid
      && $stable(axil_rsp.bresp)) else $error("write response dropped");
  a_read_answer:
    assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
      else $error("read not answered");
  for (genvar i = 0; i < NUM_EV; i++) begin : g_pend
    a_pend_calc:
      assert property (transfer_pending[i] == (transfer_enable[i]
        && request_pending_flag[i] && active_vector_number != VEC_W'(i)))
        else $error("pending wrong");
  end
endmodule
bind tef_top tef_props u_props (
  .core_clk(core_clk), .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .event_request(event_request), .irq_forward(irq_forward), .xfer(xfer),
  .active_vector_number(active_vector_number), .transfer_activate(transfer_activate),
  .transfer_enable(transfer_enable), .request_pending_flag(request_pending_flag),
  .transfer_pending(transfer_pending)
);
`default_nettype wire

// ===== dv/tef_top_bench.sv
`default_nettype none
module tef_top_bench
  import tef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  tef_axil_req_s     req = '0;
  tef_axil_rsp_s     rsp;
  logic [NUM_EV-1:0] ev = '0;
  logic [NUM_EV-1:0] fwd = '0;
  tef_xfer_s         xfer;
  logic [VEC_W-1:0]  avn;
  logic [NUM_EV-1:0] act, en, flg, pend;
  logic              sel = 1'b0;
  logic [CNT_W-1:0]  rem = '0;
  logic [3:0]        lag = 4'h2;
  int                failures = 0;
  int                n_compared = 0;
  int                cyc = 0;
  localparam logic [DW-1:0] REST = FLG_MASK_LO & ~EN_MASK_LO;

  tef_top dut (.core_clk(core_clk), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .event_request(ev), .irq_forward(fwd), .xfer(xfer), .active_vector_number(avn),
    .transfer_activate(act), .transfer_enable(en), .request_pending_flag(flg),
    .transfer_pending(pend));
  tef_far_model far (.core_clk(core_clk), .rst(rst), .transfer_activate(act),
    .sel(sel), .rem(rem), .lag(lag), .xfer(xfer), .active_vector_number(avn));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [1:0] er);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk("bresp", er, rsp.bresp);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [1:0] er);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    chk("rdata", e, rsp.rdata);
    chk("rresp", er, rsp.rresp);
  endtask

  task automatic pulse(input logic [NUM_EV-1:0] e, input logic [NUM_EV-1:0] f);
    ev <= e;
    fwd <= f;
    @(posedge core_clk);
    ev <= '0;
    fwd <= '0;
  endtask

  task automatic t_reset();
    rd(OFS_CLR_LO, 32'h0, RESP_OKAY);
    rd(OFS_CLR_HI, 32'h0, RESP_OKAY);
    rd(OFS_FLG_LO, 32'h0, RESP_OKAY);
    rd(12'h3F0, 32'h0, RESP_SLVERR);
    wr(12'h3F0, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("t_reset done");
  endtask

  task automatic t_flags();
    pulse('1, '0);
    rd(OFS_FLG_LO, FLG_MASK_LO, RESP_OKAY);
    rd(OFS_FLG_HI, FLG_MASK_HI, RESP_OKAY);
    wr(OFS_FLG_LO, 32'h0, RESP_OKAY);
    rd(OFS_FLG_LO, FLG_MASK_LO, RESP_OKAY);
    wr(OFS_CLR_LO, 32'h0000_0008, RESP_OKAY);
    wr(OFS_SET_LO, 32'h0000_0010, RESP_OKAY);
    pulse('0, 42'h20);
    rd(OFS_FLG_LO, FLG_MASK_LO & ~32'h38, RESP_OKAY);
    $display("t_flags done");
  endtask

  task automatic t_enable();
    wr(OFS_SET_LO, EN_MASK_LO, RESP_OKAY);
    wr(OFS_SET_HI, EN_MASK_HI, RESP_OKAY);
    rd(OFS_ST_LO, EN_MASK_LO, RESP_OKAY);
    rd(OFS_ST_HI, EN_MASK_HI, RESP_OKAY);
    rd(OFS_FLG_LO, REST, RESP_OKAY);
    wr(OFS_CLR_LO, 32'h0, RESP_OKAY);
    rd(OFS_ST_LO, EN_MASK_LO, RESP_OKAY);
    wr(OFS_CLR_LO, EN_MASK_LO & ~32'h2, RESP_OKAY);
    wr(OFS_CLR_HI, EN_MASK_HI, RESP_OKAY);
    chk("enable", 42'h2, en);
    pulse(42'h4, '0);
    @(posedge core_clk);
    chk("activate", 42'h0, act);
    rd(OFS_CLR_LO, 32'h0, RESP_OKAY);
    $display("t_enable done");
  endtask

  task automatic t_xfer();
    for (int i = 0; i < 3; i++) begin
      sel <= i == 2;
      rem <= (i == 1) ? 16'h0000 : 16'h0005;
      // The done pulse must come after the flag read that follows start.
      lag <= (i == 0) ? 4'h4 : 4'h9;
      wr(OFS_SET_LO, 32'h0000_0004, RESP_OKAY);
      pulse(42'h4, '0);
      @(posedge core_clk);
      chk("activate", 42'h4, act);
      rd(OFS_PEND_LO, 32'h0000_0004, RESP_OKAY);
      do @(posedge core_clk); while (xfer.start !== 1'b1);
      rd(OFS_FLG_LO, REST | ((i != 0) ? 32'h4 : 32'h0), RESP_OKAY);
      do @(posedge core_clk); while (xfer.done !== 1'b1);
      rd(OFS_FLG_LO, REST, RESP_OKAY);
    end
    $display("t_xfer done");
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    req.wstrb <= 4'hF;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_flags();
    t_enable();
    t_xfer();
    complete_run();
  end
endmodule
`default_nettype wire

// ===== rtl/tef_event_cell.sv
`default_nettype none
module tef_event_cell
  import tef_pkg::*;
#(
  parameter bit EN_IMPL  = 1'b1,
  parameter bit FLG_IMPL = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Software strobes, one-cycle
  input  wire logic sw_set,
  input  wire logic sw_clr,
  // Event side
  input  wire logic ev_req,
  input  wire logic hw_clr,
  // State
  output logic      en,
  output logic      flag
);

  tef_cell_s st;
  tef_cell_s next_st;

  always_comb begin
    next_st = st;
    // Clear beats set so a racing disable never leaves the event armed.
    if (!EN_IMPL) begin
      next_st.en = 1'b0;
    end else if (sw_clr) begin
      next_st.en = 1'b0;
    end else if (sw_set) begin
      next_st.en = 1'b1;
    end
    // A new request wins over any clear in the same cycle so it is not lost.
    if (!FLG_IMPL) begin
      next_st.flag = 1'b0;
    end else if (ev_req) begin
      next_st.flag = 1'b1;
    end else if (hw_clr || sw_set || sw_clr) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign en   = st.en;
  assign flag = st.flag;

endmodule
`default_nettype wire

// ===== rtl/tef_pkg.sv
`default_nettype none
package tef_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_EV = 42;
  localparam int AW     = 12;
  localparam int DW     = 32;
  localparam int VEC_W  = 8;
  localparam int CNT_W  = 16;
  localparam int HI_EV  = 32;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [AW-1:0] OFS_SET_LO  = 12'h310;
  localparam logic [AW-1:0] OFS_SET_HI  = 12'h314;
  localparam logic [AW-1:0] OFS_CLR_LO  = 12'h320;
  localparam logic [AW-1:0] OFS_CLR_HI  = 12'h324;
  localparam logic [AW-1:0] OFS_ST_LO   = 12'h328;
  localparam logic [AW-1:0] OFS_ST_HI   = 12'h32C;
  localparam logic [AW-1:0] OFS_FLG_LO  = 12'h330;
  localparam logic [AW-1:0] OFS_FLG_HI  = 12'h334;
  localparam logic [AW-1:0] OFS_PEND_LO = 12'h338;
  localparam logic [AW-1:0] OFS_PEND_HI = 12'h33C;

  // ------------------------------------------------------------------
  // Implemented bit positions and reset values
  // ------------------------------------------------------------------
  localparam logic [DW-1:0] EN_MASK_LO  = 32'hF8CD_B0FE;
  localparam logic [DW-1:0] EN_MASK_HI  = 32'h0000_037F;
  localparam logic [DW-1:0] FLG_MASK_LO = 32'hFFFF_FCFF;
  localparam logic [DW-1:0] FLG_MASK_HI = 32'h0000_03FF;
  localparam logic [DW-1:0] REG_RST     = 32'h0000_0000;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [DW-1:0] wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } tef_axil_req_s;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [DW-1:0] rdata;
    logic [1:0]    rresp;
  } tef_axil_rsp_s;

  typedef struct packed {
    logic             start;
    logic             done;
    logic [VEC_W-1:0] vector;
    logic             irq_select;
    logic [CNT_W-1:0] remaining;
  } tef_xfer_s;

  typedef struct packed {
    logic en;
    logic flag;
  } tef_cell_s;

  typedef struct packed {
    logic              aw_held;
    logic [AW-1:0]     awaddr;
    logic              w_held;
    logic [DW-1:0]     wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DW-1:0]     rdata;
    logic [1:0]        rresp;
    logic [NUM_EV-1:0] act;
  } tef_top_s;

endpackage
`default_nettype wire

// ===== rtl/tef_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none
// Summary of operation
// - A 1 written to an event's enable-clear bit stops that event from activating transfers.
// - A 0 written to a clear bit changes nothing, and every clear bit reads back as 0.
// - The low clear register maps bit i to event i for events 1-7, 12-13, 15-16, 18-19, 22-23, 27-31.
// - The high clear register serves events 32-38 on bits 6:0 and 40-41 on bits 9:8.
// - Unimplemented clear bits read as 0 and software writes them as 0; they have no effect.
// - The low flag monitor is read-only with events 0-7 and 10-31, and bits 9:8 read as 0.
// - An accepted interrupt or activation request sets the event's request flag.
// - Forwarding the event's interrupt to the processor clears its request flag.
// - A transfer start with select 0 and a nonzero remaining count clears the flag.
// - A transfer end with select 0 and zero remaining, or with select 1, clears the flag.
// - A 1 written to an event's enable-set or enable-clear bit also clears its request flag.
// - Software can see a pending request: enabled, flagged, and not the active vector.
// - A 1 written to an event's enable-set bit arms that event as a transfer source.
module tef_top
  import tef_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Register bus
  input  wire tef_axil_req_s     axil_req,
  output tef_axil_rsp_s          axil_rsp,
  // Event sources
  input  wire logic [NUM_EV-1:0] event_request,
  input  wire logic [NUM_EV-1:0] irq_forward,
  // Transfer controller
  input  wire tef_xfer_s         xfer,
  input  wire logic [VEC_W-1:0]  active_vector_number,
  output logic      [NUM_EV-1:0] transfer_activate,
  output logic      [NUM_EV-1:0] transfer_enable,
  // Monitors
  output logic      [NUM_EV-1:0] request_pending_flag,
  output logic      [NUM_EV-1:0] transfer_pending
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  tef_top_s st;
  tef_top_s next_st;

  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_go;
  logic [DW-1:0]     strb_mask;
  logic [DW-1:0]     wr_bits;
  logic              wr_hit;
  logic [63:0]       set_vec;
  logic [63:0]       clr_vec;
  logic [63:0]       en64;
  logic [63:0]       flg64;
  logic [63:0]       pend64;
  logic [DW-1:0]     rd_data;
  logic              rd_hit;
  logic [NUM_EV-1:0] en_vec;
  logic [NUM_EV-1:0] flg_vec;
  logic [NUM_EV-1:0] hw_clr;

  localparam logic [63:0] EN_IMPL64  = {EN_MASK_HI, EN_MASK_LO};
  localparam logic [63:0] FLG_IMPL64 = {FLG_MASK_HI, FLG_MASK_LO};

  // ------------------------------------------------------------------
  // Bus handshakes
  // ------------------------------------------------------------------
  // Address and data are held separately so they may arrive in either
  // order; no new write is taken while a response is still waiting.
  assign axil_rsp.awready = ~st.aw_held & ~st.bvalid;
  assign axil_rsp.wready  = ~st.w_held & ~st.bvalid;
  assign axil_rsp.arready = ~st.rvalid;
  assign axil_rsp.bvalid  = st.bvalid;
  assign axil_rsp.bresp   = st.bresp;
  assign axil_rsp.rvalid  = st.rvalid;
  assign axil_rsp.rdata   = st.rdata;
  assign axil_rsp.rresp   = st.rresp;

  assign aw_take = axil_req.awvalid & axil_rsp.awready;
  assign w_take  = axil_req.wvalid & axil_rsp.wready;
  assign ar_take = axil_req.arvalid & axil_rsp.arready;
  assign wr_go   = st.aw_held & st.w_held & ~st.bvalid;

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  assign strb_mask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}},
                      {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
  assign wr_bits   = st.wdata & strb_mask;

  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    wr_hit  = 1'b1;
    case (st.awaddr)
      OFS_SET_LO: begin
        set_vec = {REG_RST, wr_bits};
      end
      OFS_SET_HI: begin
        set_vec = {wr_bits, REG_RST};
      end
      OFS_CLR_LO: begin
        clr_vec = {REG_RST, wr_bits};
      end
      OFS_CLR_HI: begin
        clr_vec = {wr_bits, REG_RST};
      end
      OFS_ST_LO, OFS_ST_HI, OFS_FLG_LO, OFS_FLG_HI, OFS_PEND_LO, OFS_PEND_HI: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
    // Strobes exist only in the cycle the write is performed, and
    // positions without an implemented enable bit are dropped here.
    set_vec = wr_go ? (set_vec & EN_IMPL64) : '0;
    clr_vec = wr_go ? (clr_vec & EN_IMPL64) : '0;
  end

  // ------------------------------------------------------------------
  // Transfer-side flag clears
  // ------------------------------------------------------------------
  // The controller's signals are on this clock, so they are used directly.
  always_comb begin
    hw_clr = irq_forward;
    for (int i = 0; i < NUM_EV; i++) begin
      if (xfer.vector == VEC_W'(i)) begin
        if (xfer.start && !xfer.irq_select && (xfer.remaining != '0)) begin
          hw_clr[i] = 1'b1;
        end
        if (xfer.done && (xfer.irq_select || (xfer.remaining == '0))) begin
          hw_clr[i] = 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Per-event cells
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NUM_EV; g++) begin : g_cell
    tef_event_cell #(
      .EN_IMPL  (EN_IMPL64[g]),
      .FLG_IMPL (FLG_IMPL64[g])
    ) u_cell (
      .core_clk (core_clk),
      .rst      (rst),
      .sw_set   (set_vec[g]),
      .sw_clr   (clr_vec[g]),
      .ev_req   (event_request[g]),
      .hw_clr   (hw_clr[g]),
      .en       (en_vec[g]),
      .flag     (flg_vec[g])
    );
  end

  // ------------------------------------------------------------------
  // Pending detection and monitors
  // ------------------------------------------------------------------
  always_comb begin
    transfer_pending = '0;
    for (int i = 0; i < NUM_EV; i++) begin
      transfer_pending[i] = en_vec[i] & flg_vec[i] &
                            (active_vector_number != VEC_W'(i));
    end
  end

  assign en64   = {{(64-NUM_EV){1'b0}}, en_vec};
  assign flg64  = {{(64-NUM_EV){1'b0}}, flg_vec} & FLG_IMPL64;
  assign pend64 = {{(64-NUM_EV){1'b0}}, transfer_pending};

  assign transfer_enable      = en_vec;
  assign request_pending_flag = flg_vec;
  assign transfer_activate    = st.act;

  // ------------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------------
  always_comb begin
    rd_data = REG_RST;
    rd_hit  = 1'b1;
    case (axil_req.araddr)
      OFS_SET_LO, OFS_SET_HI: begin
        rd_data = REG_RST;
      end
      OFS_CLR_LO, OFS_CLR_HI: begin
        rd_data = REG_RST;
      end
      OFS_ST_LO: begin
        rd_data = en64[31:0];
      end
      OFS_ST_HI: begin
        rd_data = en64[63:32];
      end
      OFS_FLG_LO: begin
        rd_data = flg64[31:0];
      end
      OFS_FLG_HI: begin
        rd_data = flg64[63:32];
      end
      OFS_PEND_LO: begin
        rd_data = pend64[31:0];
      end
      OFS_PEND_HI: begin
        rd_data = pend64[63:32];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = axil_req.awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = axil_req.wdata;
      next_st.wstrb  = axil_req.wstrb;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && axil_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_data;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && axil_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    // A request arriving with a disable in the same cycle is not passed on.
    next_st.act = event_request & en_vec & ~clr_vec[NUM_EV-1:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire
